// [hw/irq_pkg.sv]
// Shared constants and types of the motion I/O interrupt unit.
package irq_pkg;

    // ************************************************************
    // Channel and input bank geometry
    // ************************************************************
    localparam int unsigned NUM_CH = 3;
    localparam int unsigned FACE_COUNT = 8;
    localparam int unsigned TERM_COUNT = 28;
    localparam int unsigned SRC_W = 5;
    localparam int unsigned FACE_SEL_W = 3;
    localparam int unsigned IVL_W = 6;

    typedef enum logic [1:0] {
        MODE_DIS = 2'h0,
        MODE_FACE = 2'h1,
        MODE_TERM = 2'h2,
        MODE_TIMED = 2'h3
    } irq_mode_t;

    // ************************************************************
    // Register port map and field layout
    // ************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [7:0] CFG_BASE = 8'h00;
    localparam logic [7:0] CFG_STRIDE = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned FALL_BIT = 2;
    localparam int unsigned SRC_LSB = 8;
    localparam int unsigned IVL_LSB = 16;
    localparam int unsigned FAULT_LSB = 0;
    localparam int unsigned REJECT_BIT = 8;

    // ************************************************************
    // Reset values and interval limits, intervals in milliseconds
    // ************************************************************
    localparam logic FALL_RST = 1'b0;
    localparam logic [4:0] SRC_RST = 5'h00;
    localparam logic [5:0] IVL_RST_MS = 6'h0a;
    localparam logic [5:0] IVL_MIN_MS = 6'h02;
    localparam logic [5:0] IVL_MAX_MS = 6'h28;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned HOLDOFF_US = 2000;
    localparam int unsigned MS_US = 1000;
    localparam int unsigned HOLDOFF_CYCLES_DEF = HOLDOFF_US * CLK_MHZ;
    localparam int unsigned MS_CYCLES_DEF = MS_US * CLK_MHZ;

endpackage

// [hw/irq_chan_if.sv]
// Bundle between the register side and one interrupt channel engine.
`timescale 1ns/1ps
`default_nettype none
interface irq_chan_if;
    irq_pkg::irq_mode_t mode;
    logic falling;
    logic [irq_pkg::IVL_W-1:0] interval;
    logic level;
    logic restart;
    logic cmd_tick;
    logic fire;
    logic fault;

    modport ctrl (
        output mode, falling, interval, level, restart, cmd_tick,
        input fire, fault
    );
    modport channel (
        input mode, falling, interval, level, restart, cmd_tick,
        output fire, fault
    );
endinterface
`default_nettype wire

// [hw/irq_channel.sv]
// One interrupt channel: edge qualification with spacing guard, or periodic timer.
`timescale 1ns/1ps
`default_nettype none
module irq_channel #(
    parameter int unsigned HOLDOFF_CYCLES = irq_pkg::HOLDOFF_CYCLES_DEF,
    parameter int unsigned MS_CYCLES = irq_pkg::MS_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    irq_chan_if.channel chan
);
    import irq_pkg::*;

    localparam int HW = $clog2(HOLDOFF_CYCLES + 1);
    localparam int MW = $clog2(MS_CYCLES + 1);

    if (HOLDOFF_CYCLES < 1 || MS_CYCLES < 1) begin : g_bad_param
        $error("irq_channel: cycle counts must be at least one");
    end

    logic prev;
    logic next_prev;
    logic [HW-1:0] hold;
    logic [HW-1:0] next_hold;
    logic [MW-1:0] ms_cnt;
    logic [MW-1:0] next_ms_cnt;
    logic [IVL_W-1:0] elapsed;
    logic [IVL_W-1:0] next_elapsed;
    logic tpend;
    logic next_tpend;
    logic fire;
    logic next_fire;
    logic fault;
    logic next_fault;
    logic in_mode;
    logic qual_edge;

    assign in_mode = (chan.mode == MODE_FACE) || (chan.mode == MODE_TERM);
    // Polarity only matters in the input modes; falling selects the 1-to-0 edge.
    assign qual_edge = (prev ^ chan.level) & (chan.level ^ chan.falling);
    assign chan.fire = fire;
    assign chan.fault = fault;

    always_comb begin
        next_prev = chan.level;
        next_hold = hold;
        next_ms_cnt = ms_cnt;
        next_elapsed = elapsed;
        next_tpend = tpend;
        next_fire = 1'b0;
        next_fault = 1'b0;
        if (hold != '0) begin
            next_hold = hold - 1'b1;
        end
        // A fresh configuration starts from a clean slate so the old source
        // cannot leave a phantom edge behind.
        if (chan.restart) begin
            next_hold = '0;
            next_ms_cnt = '0;
            next_elapsed = '0;
            next_tpend = 1'b0;
        end else if (in_mode) begin
            if (qual_edge) begin
                if (hold == '0) begin
                    next_fire = 1'b1;
                    next_hold = HW'(HOLDOFF_CYCLES - 1);
                end else begin
                    next_fault = 1'b1;
                end
            end
        end else if (chan.mode == MODE_TIMED) begin
            // The period runs on its own; only the release waits for the
            // command-processing tick, so jitter does not accumulate.
            if (chan.cmd_tick && tpend) begin
                next_fire = 1'b1;
                next_tpend = 1'b0;
            end
            if (ms_cnt == MW'(MS_CYCLES - 1)) begin
                next_ms_cnt = '0;
                if (elapsed == chan.interval - 6'h01) begin
                    next_elapsed = '0;
                    next_tpend = 1'b1;
                end else begin
                    next_elapsed = elapsed + 6'h01;
                end
            end else begin
                next_ms_cnt = ms_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prev <= 1'b0;
            hold <= '0;
            ms_cnt <= '0;
            elapsed <= '0;
            tpend <= 1'b0;
            fire <= 1'b0;
            fault <= 1'b0;
        end else if (ce) begin
            prev <= next_prev;
            hold <= next_hold;
            ms_cnt <= next_ms_cnt;
            elapsed <= next_elapsed;
            tpend <= next_tpend;
            fire <= next_fire;
            fault <= next_fault;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_disabled_quiet: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (ce && chan.mode == MODE_DIS) |=> !fire)
        else $error("disabled channel fired");

    a_edge_accept: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (ce && in_mode && !chan.restart && qual_edge && hold == '0) |=> fire)
        else $error("qualifying edge not accepted");

    a_holdoff_load: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (fire && $past(ce) && $past(in_mode)) |-> (hold == HW'(HOLDOFF_CYCLES - 1)))
        else $error("spacing guard not loaded after trigger");

    a_fault_discard: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (fault && $past(ce)) |-> (!fire && $past(hold) != '0))
        else $error("fault without early edge");

    a_timed_tick: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (fire && $past(ce) && $past(chan.mode) == MODE_TIMED) |-> $past(chan.cmd_tick))
        else $error("timed interrupt off the command cycle");
endmodule
`default_nettype wire

// [hw/motion_io_interrupt_unit.sv]
// Top of the motion I/O interrupt unit: register port, input capture, three channels.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module motion_io_interrupt_unit #(
    parameter int unsigned HOLDOFF_CYCLES = irq_pkg::HOLDOFF_CYCLES_DEF,
    parameter int unsigned MS_CYCLES = irq_pkg::MS_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [irq_pkg::ADDR_W-1:0] addr,
    input wire logic [irq_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [irq_pkg::DATA_W-1:0] rdata,
    input wire logic [irq_pkg::FACE_COUNT-1:0] faceplate_input_bank,
    input wire logic [irq_pkg::TERM_COUNT-1:0] remote_terminal_input_bank,
    input wire logic cmd_cycle_tick,
    output logic [irq_pkg::NUM_CH-1:0] status_data,
    output logic [irq_pkg::NUM_CH-1:0] fault
);
    import irq_pkg::*;

    // The channel engines need at least one cycle per spacing window and per
    // millisecond; smaller values leave their counters nothing to count.
    if (HOLDOFF_CYCLES < 1 || MS_CYCLES < 1) begin : g_bad_param
        $error("motion_io_interrupt_unit: cycle counts must be at least one");
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    irq_mode_t cfg_mode [NUM_CH];
    irq_mode_t next_cfg_mode [NUM_CH];
    logic [NUM_CH-1:0] cfg_fall;
    logic [NUM_CH-1:0] next_cfg_fall;
    logic [SRC_W-1:0] cfg_src [NUM_CH];
    logic [SRC_W-1:0] next_cfg_src [NUM_CH];
    logic [IVL_W-1:0] cfg_ivl [NUM_CH];
    logic [IVL_W-1:0] next_cfg_ivl [NUM_CH];
    logic [NUM_CH-1:0] restart;
    logic [NUM_CH-1:0] next_restart;
    logic reject;
    logic next_reject;
    logic [NUM_CH-1:0] next_fault;
    logic [NUM_CH-1:0] next_status_data;
    logic [DATA_W-1:0] next_rdata;
    logic [NUM_CH-1:0] cfg_hit;
    logic [NUM_CH-1:0] cfg_ok;
    logic status_hit;
    logic [NUM_CH-1:0] fire_vec;
    logic [NUM_CH-1:0] fault_vec;
    irq_mode_t wr_mode;
    logic [IVL_W-1:0] wr_ivl;

    assign wr_mode = irq_mode_t'(wdata[MODE_LSB +: 2]);
    assign wr_ivl = wdata[IVL_LSB +: IVL_W];
    assign status_hit = (addr == STATUS_OFS);

    // A write is refused whole when it would make a second channel timed or
    // asks for an interval outside the supported span.
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            cfg_hit[i] = (addr == ADDR_W'(CFG_BASE + i * CFG_STRIDE));
            cfg_ok[i] = (wr_ivl >= IVL_MIN_MS) && (wr_ivl <= IVL_MAX_MS);
            for (int j = 0; j < NUM_CH; j++) begin
                if (j != i && wr_mode == MODE_TIMED && cfg_mode[j] == MODE_TIMED) begin
                    cfg_ok[i] = 1'b0;
                end
            end
        end
    end

    always_comb begin
        next_reject = reject;
        for (int i = 0; i < NUM_CH; i++) begin
            next_cfg_mode[i] = cfg_mode[i];
            next_cfg_fall[i] = cfg_fall[i];
            next_cfg_src[i] = cfg_src[i];
            next_cfg_ivl[i] = cfg_ivl[i];
            next_restart[i] = 1'b0;
        end
        if (wr && status_hit && wdata[REJECT_BIT]) begin
            next_reject = 1'b0;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (wr && cfg_hit[i]) begin
                if (cfg_ok[i]) begin
                    next_cfg_mode[i] = wr_mode;
                    next_cfg_fall[i] = wdata[FALL_BIT];
                    next_cfg_src[i] = wdata[SRC_LSB +: SRC_W];
                    next_cfg_ivl[i] = wr_ivl;
                    next_restart[i] = 1'b1;
                end else begin
                    next_reject = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                cfg_mode[i] <= MODE_DIS;
                cfg_src[i] <= SRC_RST;
                cfg_ivl[i] <= IVL_RST_MS;
            end
            cfg_fall <= {NUM_CH{FALL_RST}};
            restart <= '0;
            reject <= 1'b0;
        end else if (ce) begin
            for (int i = 0; i < NUM_CH; i++) begin
                cfg_mode[i] <= next_cfg_mode[i];
                cfg_src[i] <= next_cfg_src[i];
                cfg_ivl[i] <= next_cfg_ivl[i];
            end
            cfg_fall <= next_cfg_fall;
            restart <= next_restart;
            reject <= next_reject;
        end
    end

    // ************************************************************
    // Input capture
    // ************************************************************
    // Two stages per pin; the first stage feeds only the second.
    logic [FACE_COUNT-1:0] face_meta;
    logic [FACE_COUNT-1:0] face_sync;
    logic [TERM_COUNT-1:0] term_meta;
    logic [TERM_COUNT-1:0] term_sync;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            face_meta <= '0;
            face_sync <= '0;
            term_meta <= '0;
            term_sync <= '0;
        end else if (ce) begin
            face_meta <= faceplate_input_bank;
            face_sync <= face_meta;
            term_meta <= remote_terminal_input_bank;
            term_sync <= term_meta;
        end
    end

    // ************************************************************
    // Channel engines
    // ************************************************************
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        irq_chan_if ch_if ();
        logic level_sel;

        // An out-of-range selector falls back to input 0 of the bank.
        always_comb begin
            if (cfg_mode[i] == MODE_TERM) begin
                level_sel = (cfg_src[i] < SRC_W'(TERM_COUNT)) ?
                    term_sync[cfg_src[i]] : term_sync[0];
            end else begin
                level_sel = (cfg_src[i] < SRC_W'(FACE_COUNT)) ?
                    face_sync[cfg_src[i][FACE_SEL_W-1:0]] : face_sync[0];
            end
        end

        assign ch_if.mode = cfg_mode[i];
        assign ch_if.falling = cfg_fall[i];
        assign ch_if.interval = cfg_ivl[i];
        assign ch_if.level = level_sel;
        assign ch_if.restart = restart[i];
        assign ch_if.cmd_tick = cmd_cycle_tick;
        assign fire_vec[i] = ch_if.fire;
        assign fault_vec[i] = ch_if.fault;

        irq_channel #(
            .HOLDOFF_CYCLES(HOLDOFF_CYCLES),
            .MS_CYCLES(MS_CYCLES)
        ) u_chan (
            .mclk(mclk),
            .arst_n(arst_n),
            .ce(ce),
            .chan(ch_if)
        );
    end

    // ************************************************************
    // Status outputs and sticky faults
    // ************************************************************
    // A fault arriving in the cycle of its clear survives: set wins.
    always_comb begin
        next_status_data = fire_vec;
        next_fault = fault;
        if (wr && status_hit) begin
            next_fault = fault & ~wdata[FAULT_LSB +: NUM_CH];
        end
        next_fault = next_fault | fault_vec;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            status_data <= '0;
            fault <= '0;
        end else if (ce) begin
            status_data <= next_status_data;
            fault <= next_fault;
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    always_comb begin
        next_rdata = '0;
        if (rd) begin
            if (status_hit) begin
                next_rdata[FAULT_LSB +: NUM_CH] = fault;
                next_rdata[REJECT_BIT] = reject;
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (cfg_hit[i]) begin
                    next_rdata[MODE_LSB +: 2] = cfg_mode[i];
                    next_rdata[FALL_BIT] = cfg_fall[i];
                    next_rdata[SRC_LSB +: SRC_W] = cfg_src[i];
                    next_rdata[IVL_LSB +: IVL_W] = cfg_ivl[i];
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= next_rdata;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_single_timed: assert property (
        @(posedge mclk) disable iff (!arst_n)
        ((cfg_mode[0] == MODE_TIMED) + (cfg_mode[1] == MODE_TIMED) +
         (cfg_mode[2] == MODE_TIMED)) <= 2'h1)
        else $error("more than one timed channel");

    a_reject_flag: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (ce && wr && |(cfg_hit & ~cfg_ok)) |=> reject)
        else $error("refused write did not flag");

    a_status_follow: assert property (
        @(posedge mclk) disable iff (!arst_n)
        $past(ce) |-> (status_data == $past(fire_vec)))
        else $error("status bits do not follow channel interrupts");

    a_fault_sticky: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (ce && fault[0] && !(wr && status_hit)) |=> fault[0])
        else $error("fault lost without a clear");

    a_unmapped_zero: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (ce && rd && !status_hit && cfg_hit == '0) |=> (rdata == '0))
        else $error("unmapped read not zero");

    a_refused_keep: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (ce && wr && cfg_hit[0] && !cfg_ok[0]) |=> (cfg_mode[0] == $past(cfg_mode[0])))
        else $error("refused write changed the configuration");

    a_reject_hold: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (ce && reject && !(wr && status_hit)) |=> reject)
        else $error("reject flag lost without a clear");

    a_fault_set: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (ce && fault_vec != '0) |=> ((fault & $past(fault_vec)) == $past(fault_vec)))
        else $error("channel fault not recorded");

    a_read_idle: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (ce && !rd) |=> (rdata == '0))
        else $error("read data outside the read cycle");

    a_sync_stage: assert property (
        @(posedge mclk) disable iff (!arst_n)
        ce |=> (face_sync == $past(face_meta) && term_sync == $past(term_meta)))
        else $error("input synchroniser skipped a stage");
endmodule
`default_nettype wire

// [verification/host_irq_model.sv]
// Host side model: counts the interrupt pulses that would start interrupt blocks.
`timescale 1ns/1ps
`default_nettype none
module host_irq_model (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [2:0] status_data,
    output logic [47:0] hits
);
    // ************************************************************
    // Pulse counting, sixteen bits per channel
    // ************************************************************
    logic [47:0] next_hits;

    // A pulse is one cycle long, so every sampled high is one interrupt block run.
    always_comb begin
        next_hits = hits;
        for (int i = 0; i < 3; i++) begin
            if (status_data[i]) begin
                next_hits[i*16 +: 16] = hits[i*16 +: 16] + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hits <= '0;
        end else begin
            hits <= next_hits;
        end
    end
endmodule
`default_nettype wire

// [verification/motion_io_interrupt_unit_tb.sv]
// Self-checking testbench of the motion I/O interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module motion_io_interrupt_unit_tb;
    import irq_pkg::*;
    localparam int HOLD = 20;
    localparam int MSC = 10;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [7:0] face_pins = 8'h00;
    logic [27:0] term_pins = 28'h0;
    logic tick = 1'b0;
    logic [2:0] status_data;
    logic [2:0] fault;
    logic [47:0] hits;
    logic [1:0] tick_hist = 2'h0;
    int bad_count = 0;
    int n_tests = 0;
    int exp_hits[3] = '{0, 0, 0};
    int cyc;
    int np = 0;
    logic [31:0] val;

    always #2 mclk = ~mclk;
    always @(posedge mclk) tick_hist <= {tick_hist[0], tick};

    motion_io_interrupt_unit #(.HOLDOFF_CYCLES(HOLD), .MS_CYCLES(MSC)) i_dut (
        .mclk(mclk), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .faceplate_input_bank(face_pins),
        .remote_terminal_input_bank(term_pins), .cmd_cycle_tick(tick),
        .status_data(status_data), .fault(fault)
    );
    host_irq_model i_host (.mclk(mclk), .arst_n(arst_n), .status_data(status_data), .hits(hits));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] cfg(int mode, int fall, int src, int ivl);
        return (32'(mode) << MODE_LSB) | (32'(fall) << FALL_BIT)
            | (32'(src) << SRC_LSB) | (32'(ivl) << IVL_LSB);
    endfunction

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Eight cycles cover the two synchroniser flops, the channel and the status register.
    task automatic pin(input bit term, input int idx, input bit v, input int hit_ch);
        @(posedge mclk);
        if (term) begin
            term_pins[idx] <= v;
        end else begin
            face_pins[idx] <= v;
        end
        if (hit_ch >= 0) exp_hits[hit_ch]++;
        repeat (8) @(posedge mclk);
        for (int c = 0; c < 3; c++) check(32'(hits[c*16 +: 16]), 32'(exp_hits[c]));
    endtask

    task automatic wait_pulse(input int bound, output int n);
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (status_data[2] !== 1'b1 && n < bound);
        check(32'(status_data[2]), 32'h1);
        if (status_data[2] !== 1'b1) begin
            summarize();
        end
    endtask

    task automatic refused(input logic [7:0] a, input logic [31:0] d);
        wr_reg(a, d);
        rd_reg(STATUS_OFS, val);
        check(val & 32'h100, 32'h100);
        wr_reg(STATUS_OFS, 32'h100);
        rd_reg(STATUS_OFS, val);
        check(val & 32'h100, 32'h0);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h01e0));
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            rd_reg(CFG_BASE + 8'(c) * CFG_STRIDE, val);
            check(val, cfg(0, 0, 0, 10));
        end
        rd_reg(STATUS_OFS, val);
        check(val, 32'h0);
        rd_reg(8'h10, val);
        check(val, 32'h0);
        $display("test reset_values done");
        pin(0, 0, 1, -1);
        pin(1, 0, 1, -1);
        pin(0, 0, 0, -1);
        pin(1, 0, 0, -1);
        $display("test disabled done");
        // Sources are chosen before any edge is applied to them.
        wr_reg(CFG_BASE, cfg(1, 0, 0, 10));
        wr_reg(CFG_BASE + CFG_STRIDE, cfg(2, 1, 27, 10));
        wr_reg(CFG_BASE + 2 * CFG_STRIDE, cfg(2, 0, 31, 10));
        pin(0, 1, 1, -1);
        pin(0, 0, 1, 0);
        pin(1, 27, 1, -1);
        pin(1, 27, 0, 1);
        pin(1, 0, 1, 2);
        $display("test edges done");
        pin(0, 0, 0, -1);
        pin(0, 0, 1, 0);
        pin(0, 0, 0, -1);
        pin(0, 0, 1, -1);
        check(32'(fault), 32'h1);
        rd_reg(STATUS_OFS, val);
        check(val, 32'h1);
        wr_reg(STATUS_OFS, 32'h1);
        rd_reg(STATUS_OFS, val);
        check(val, 32'h0);
        check(32'(fault), 32'h0);
        pin(0, 0, 0, -1);
        pin(0, 0, 1, 0);
        $display("test spacing done");
        @(posedge mclk);
        ce <= 1'b0;
        wr_reg(CFG_BASE, cfg(0, 0, 0, 10));
        ce <= 1'b1;
        rd_reg(CFG_BASE, val);
        check(val, cfg(1, 0, 0, 10));
        $display("test clock_enable done");
        tick <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            automatic int ivl = (k == 0) ? 2 : (k == 1) ? 10 : 40;
            wr_reg(CFG_BASE + 2 * CFG_STRIDE, cfg(3, 0, 0, ivl));
            rd_reg(CFG_BASE + 2 * CFG_STRIDE, val);
            check(val, cfg(3, 0, 0, ivl));
            wait_pulse(ivl * MSC + 20, cyc);
            wait_pulse(ivl * MSC + 20, cyc);
            check(32'(cyc), 32'(ivl * MSC));
        end
        $display("test timed done");
        wr_reg(CFG_BASE + 2 * CFG_STRIDE, cfg(3, 0, 0, 2));
        refused(CFG_BASE, cfg(3, 0, 0, 10));
        refused(CFG_BASE + CFG_STRIDE, cfg(2, 1, 27, 41));
        refused(CFG_BASE + CFG_STRIDE, cfg(1, 0, 0, 1));
        rd_reg(CFG_BASE, val);
        check(val, cfg(1, 0, 0, 10));
        rd_reg(CFG_BASE + CFG_STRIDE, val);
        check(val, cfg(2, 1, 27, 10));
        $display("test refusals done");
        for (int i = 0; i < 300; i++) begin
            @(posedge mclk);
            tick <= ($urandom % 4 == 0);
            #1;
            if (status_data[2] === 1'b1) begin
                np++;
                check(32'(tick_hist[1]), 32'h1);
            end
        end
        check(32'(np > 0), 32'h1);
        for (int c = 0; c < 2; c++) check(32'(hits[c*16 +: 16]), 32'(exp_hits[c]));
        $display("test alignment done");
        // A reset in mid-run must bring back the defaults of a timed channel too.
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        rd_reg(CFG_BASE + 2 * CFG_STRIDE, val);
        check(val, cfg(0, 0, 0, 10));
        $display("test mid_reset done");
        summarize();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
